// File: hdl/acc_pkg.sv
package acc_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h45;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h46;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h47;
  // control/status field positions
  localparam int BIT_DONE  = 7;
  localparam int BIT_SPEED = 6;
  localparam int BIT_ON    = 5;
  localparam int BIT_SLOW  = 4;
  localparam int CH_MSB    = 3;
  localparam logic [7:0] CSR_RESET    = 8'h00;
  localparam logic [7:0] CSR_WR_MASK  = 8'h7F;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [7:0] FULL_HIGH    = 8'hFF;
  localparam logic [7:0] FULL_LOW     = 8'h03;
  // timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES  =
    (SETTLE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int RESULT_BITS    = 10;
  // divider select codes {slow, speed}
  localparam logic [1:0] DIV_SEL_HALF0 = 2'h0;
  localparam logic [1:0] DIV_SEL_FULL  = 2'h1;
  localparam logic [1:0] DIV_SEL_QUART = 2'h2;
  localparam logic [1:0] DIV_SEL_HALF1 = 2'h3;
endpackage

// File: hdl/acc_sar_if.sv
`timescale 1ns/100ps
interface acc_sar_if;
  logic       tick;      // one converter-clock step
  logic       start;     // begin a new conversion
  logic       clear;     // abort
  logic       comp;      // comparator: sample above trial code
  logic [9:0] trial;
  logic [9:0] result;
  logic       done;      // one-cycle pulse
  modport ctrl (output tick, start, clear, comp, input trial, result, done);
  modport sar  (input tick, start, clear, comp, output trial, result, done);
endinterface

// File: hdl/acc_sar.sv
`timescale 1ns/100ps
module acc_sar (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // converter side
  acc_sar_if.sar   sif
);
  typedef struct packed {
    logic       busy;
    logic [3:0] bit_idx;
    logic [9:0] code;
    logic [9:0] result;
    logic       done;
  } acc_sar_state_t;

  acc_sar_state_t st_reg;
  acc_sar_state_t st_next;

  // binary search keeps the code monotonic in the input
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (sif.clear) begin
      st_next.busy = 1'b0;
    end else if (sif.start) begin
      st_next.busy = 1'b1;
      st_next.bit_idx = 4'(acc_pkg::RESULT_BITS - 1);
      st_next.code = 10'h200;
    end else if (st_reg.busy && sif.tick) begin
      if (!sif.comp) begin
        st_next.code[st_reg.bit_idx] = 1'b0;
      end
      if (st_reg.bit_idx == 4'h0) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.result = st_reg.code;
        if (!sif.comp) begin
          st_next.result[0] = 1'b0;
        end
      end else begin
        st_next.bit_idx = st_reg.bit_idx - 4'h1;
        st_next.code[st_reg.bit_idx - 4'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sif.trial  = st_reg.code;
  assign sif.result = st_reg.result;
  assign sif.done   = st_reg.done;
endmodule

// File: hdl/acc_top.sv
`timescale 1ns/100ps
module acc_top #(
  parameter int SETTLE_CYCLES = acc_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  // power modes
  input  wire logic       wait_mode,
  input  wire logic       halt_mode,
  // analog core
  input  wire logic       comp_above,
  input  wire logic       above_upper,
  input  wire logic       below_lower,
  output logic      [3:0] mux_select,
  output logic      [9:0] dac_code,
  output logic            sample_hold,
  output logic            converter_power,
  output logic            result_settled
);
  initial begin
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin
      $error("SETTLE_CYCLES out of range");
    end
  end

  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
  } acc_state_t;

  typedef struct packed {
    acc_state_t  state;
    logic        done;
    logic        speed;
    logic        on;
    logic        slow;
    logic [3:0]  channel;
    logic [9:0]  result;
    logic        locked;
    logic [1:0]  div_cnt;
    logic        tick;
    logic [15:0] settle_cnt;
    logic        halted;
    logic [7:0]  rdata;
    logic [3:0]  mux;
    logic        power;
    logic        settled;
    logic        sh;
  } acc_regs_t;

  acc_regs_t r_reg;
  acc_regs_t r_next;
  acc_sar_if sif ();

  acc_sar u_sar (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif)
  );

  // divide ratio minus one for the converter clock
  function automatic logic [1:0] div_limit(input logic slow,
                                           input logic speed);
    logic [1:0] sel;
    sel = {slow, speed};
    if (sel == acc_pkg::DIV_SEL_FULL) begin
      div_limit = 2'h0;
    end else if (sel == acc_pkg::DIV_SEL_QUART) begin
      div_limit = 2'h3;
    end else begin
      div_limit = 2'h1;
    end
  endfunction

  logic       wr_csr;
  logic       rd_high;
  logic       rd_low;
  logic       ch_change;
  logic       run_ok;
  logic       start_conv;
  logic [9:0] final_code;

  always_comb begin
    wr_csr  = wr_en && addr == acc_pkg::ADDR_CTRL_STATUS;
    rd_high = rd_en && addr == acc_pkg::ADDR_RESULT_HIGH;
    rd_low  = rd_en && addr == acc_pkg::ADDR_RESULT_LOW;
    ch_change = wr_csr && wdata[acc_pkg::CH_MSB:0] != r_reg.channel;
    // wait mode has no effect, halt stops the converter
    run_ok = r_reg.on && !halt_mode;
    // clamp codes at the reference rails
    if (above_upper) begin
      final_code = {acc_pkg::FULL_HIGH, acc_pkg::FULL_LOW[1:0]};
    end else if (below_lower) begin
      final_code = acc_pkg::RESULT_RESET;
    end else begin
      final_code = sif.result;
    end
  end

  always_comb begin
    r_next = r_reg;
    start_conv = 1'b0;
    r_next.tick = 1'b0;
    // converter clock divider
    if (r_reg.div_cnt >= div_limit(r_reg.slow, r_reg.speed)) begin
      r_next.div_cnt = 2'h0;
      r_next.tick = 1'b1;
    end else begin
      r_next.div_cnt = r_reg.div_cnt + 2'h1;
    end
    // register writes; done bit is not writable
    if (wr_csr) begin
      r_next.speed   = wdata[acc_pkg::BIT_SPEED];
      r_next.on      = wdata[acc_pkg::BIT_ON];
      r_next.slow    = wdata[acc_pkg::BIT_SLOW];
      r_next.channel = wdata[acc_pkg::CH_MSB:0];
    end
    // lock handling; release before set so a low read relocks
    if (rd_high || (wr_csr && !wdata[acc_pkg::BIT_ON])) begin
      r_next.locked = 1'b0;
    end
    if (rd_low) begin
      r_next.locked = 1'b1;
    end
    // flag clear by software
    if (rd_high || wr_csr) begin
      r_next.done = 1'b0;
    end
    // halt and wakeup settle
    r_next.halted = halt_mode;
    if (halt_mode) begin
      r_next.settle_cnt = 16'(SETTLE_CYCLES);
      r_next.settled = 1'b0;
    end else if (r_reg.settle_cnt != 16'h0) begin
      r_next.settle_cnt = r_reg.settle_cnt - 16'h1;
    end else begin
      r_next.settled = 1'b1;
    end
    // sequencer
    case (r_reg.state)
      ST_OFF: begin
        if (run_ok) begin
          r_next.state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (!run_ok) begin
          r_next.state = ST_OFF;
        end else if (r_reg.tick && !ch_change) begin
          // a channel write in this cycle must not start on the old input
          r_next.state = ST_CONV;
          start_conv = 1'b1;
          r_next.mux = r_reg.channel;
        end
      end
      ST_CONV: begin
        if (!run_ok || (wr_csr && !wdata[acc_pkg::BIT_ON])) begin
          r_next.state = ST_OFF;
        end else if (ch_change) begin
          r_next.state = ST_SAMPLE;
          r_next.done = 1'b0;
        end else if (sif.done) begin
          r_next.state = ST_SAMPLE;
          // a completion beats a same-cycle software clear
          r_next.done = 1'b1;
          if (!r_next.locked) begin
            r_next.result = final_code;
          end
        end
      end
      default: r_next.state = ST_OFF;
    endcase
    r_next.sh = r_next.state == ST_SAMPLE;
    r_next.power = r_next.state != ST_OFF;
    // read data, one cycle after the strobe
    r_next.rdata = 8'h00;
    if (rd_en && addr == acc_pkg::ADDR_CTRL_STATUS) begin
      r_next.rdata = {r_reg.done, r_reg.speed, r_reg.on, r_reg.slow,
                      r_reg.channel};
    end else if (rd_high) begin
      r_next.rdata = r_reg.result[9:2];
    end else if (rd_low) begin
      r_next.rdata = {6'h00, r_reg.result[1:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{state: ST_OFF, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sif.tick  = r_reg.tick;
  assign sif.start = start_conv;
  // clear outside a conversion or on a channel change or stop during one, never in the cycle that starts one
  assign sif.clear = !start_conv &&
                     (r_reg.state != ST_CONV || ch_change || !run_ok);
  assign sif.comp  = comp_above;

  always_comb begin
    rdata           = r_reg.rdata;
    mux_select      = r_reg.mux;
    dac_code        = sif.trial;
    sample_hold     = r_reg.sh;
    converter_power = r_reg.power;
    result_settled  = r_reg.settled;
  end

  chk_flag_on_done: assert property (@(posedge clk) disable iff (!rst_n)
    (r_reg.state == ST_CONV && sif.done && run_ok && !ch_change &&
     !(wr_csr && !wdata[acc_pkg::BIT_ON]))
    |=> r_reg.done) else $error("done flag not set");
  chk_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_high && !(r_reg.state == ST_CONV && sif.done))
    |=> !r_reg.done) else $error("done flag not cleared");
  chk_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (r_reg.locked && !rd_high && !wr_csr) |=> $stable(r_reg.result))
    else $error("locked result changed");
  chk_lock_set: assert property (@(posedge clk) disable iff (!rst_n)
    rd_low |=> r_reg.locked) else $error("low read did not lock");
  chk_mux_stable: assert property (@(posedge clk) disable iff (!rst_n)
    (r_reg.state == ST_CONV && $past(r_reg.state) == ST_CONV)
    |-> $stable(r_reg.mux)) else $error("mux moved mid conversion");
  chk_off_stop: assert property (@(posedge clk) disable iff (!rst_n)
    (r_reg.state != ST_OFF && !run_ok) |=> r_reg.state == ST_OFF)
    else $error("conversion not stopped");
  chk_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd_low |=> rdata[7:2] == 6'h00) else $error("low high bits set");
  chk_high_data: assert property (@(posedge clk) disable iff (!rst_n)
    rd_high |=> rdata == $past(r_reg.result[9:2]))
    else $error("high read data wrong");
endmodule

// File: test/acc_analog_model.sv
`timescale 1ns/100ps
module acc_analog_model (
  // converter side
  input  wire logic [3:0]       mux_select,
  input  wire logic [9:0]       dac_code,
  input  wire logic             converter_power,
  // scene set by the bench
  input  wire logic [15:0][9:0] level,
  input  wire logic             over,
  input  wire logic             under,
  // answers to the block
  output logic                  comp_above,
  output logic                  above_upper,
  output logic                  below_lower
);
  // comparator sees only the selected input
  assign comp_above  = level[mux_select] >= dac_code;
  // clamp detectors are dead while the core is unpowered
  assign above_upper = over & converter_power;
  assign below_lower = under & converter_power;
endmodule

// File: test/test_adc_conversion_control.sv
`timescale 1ns/100ps
module test_adc_conversion_control;
  typedef struct packed {
    logic [7:0] csr;
    logic [9:0] code;
    logic       over;
    logic       under;
    logic       wt;
  } acc_row_t;
  localparam logic [7:0] CS = acc_pkg::ADDR_CTRL_STATUS;
  localparam logic [7:0] HI = acc_pkg::ADDR_RESULT_HIGH;
  localparam logic [7:0] LO = acc_pkg::ADDR_RESULT_LOW;
  localparam int         SC = 2;
  logic             clk, rst_n, wr_en, rd_en, wait_mode, halt_mode;
  logic             comp_above, above_upper, below_lower;
  logic             converter_power, result_settled, over, under;
  logic [7:0]       addr, wdata, rdata, v;
  logic [3:0]       mux_select;
  logic [9:0]       dac_code;
  logic [15:0][9:0] level;
  int               mismatches, check_count;
  acc_row_t         r;
  acc_row_t         rows [8] = '{
    '{8'h20, 10'h2B6, 1'b0, 1'b0, 1'b0}, '{8'h75, 10'h155, 1'b0, 1'b0, 1'b1},
    '{8'h3A, 10'h001, 1'b0, 1'b0, 1'b0}, '{8'h7F, 10'h3FE, 1'b0, 1'b0, 1'b1},
    '{8'h23, 10'h000, 1'b1, 1'b0, 1'b0}, '{8'h27, 10'h3FF, 1'b0, 1'b1, 1'b0},
    '{8'h21, 10'h3FF, 1'b0, 1'b0, 1'b0}, '{8'h28, 10'h000, 1'b0, 1'b0, 1'b0}};

  acc_top #(.SETTLE_CYCLES(SC)) u_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .wait_mode(wait_mode),
    .halt_mode(halt_mode), .comp_above(comp_above),
    .above_upper(above_upper), .below_lower(below_lower),
    .mux_select(mux_select), .dac_code(dac_code), .sample_hold(),
    .converter_power(converter_power), .result_settled(result_settled));

  acc_analog_model u_analog (
    .mux_select(mux_select), .dac_code(dac_code),
    .converter_power(converter_power), .level(level), .over(over),
    .under(under), .comp_above(comp_above), .above_upper(above_upper),
    .below_lower(below_lower));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  // bounded wait for the done flag
  task automatic poll;
    int n;
    n = 0;
    v = 8'h00;
    while (v[7] !== 1'b1 && n < 200) begin
      rd(CS, v);
      n++;
    end
    chk(v[7], 1'b1);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    {rst_n, wr_en, rd_en, wait_mode, halt_mode, over, under} = '0;
    {addr, wdata} = '0;
    level = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk);
      wait_mode <= r.wt;
      over <= r.over;
      under <= r.under;
      level[r.csr[3:0]] <= r.code;
      wr(CS, r.csr);
      poll();
      chk(mux_select, r.csr[3:0]);
      rd(LO, v);
      chk(v, r.over ? 8'h03 : r.under ? 8'h00 : r.code[1:0]);
      rd(HI, v);
      chk(v, r.over ? 8'hFF : r.under ? 8'h00 : r.code[9:2]);
      rd(CS, v);
      chk(v, r.csr & 8'h7F);
      wr(CS, 8'h00);
    end
    wr(CS, 8'hFF);
    rd(CS, v);
    chk(v, 8'h7F);
    rd(8'h44, v);
    chk(v, 8'h00);
    @(posedge clk);
    {over, under} <= 2'b00;
    level[2] <= 10'h2C7;
    wr(CS, 8'h22);
    poll();
    rd(LO, v);
    chk(v, 8'h03);
    @(posedge clk);
    level[2] <= 10'h13A;
    repeat (150) @(posedge clk);
    rd(HI, v);
    chk(v, 8'hB1);
    poll();
    rd(LO, v);
    chk(v, 8'h02);
    rd(HI, v);
    chk(v, 8'h4E);
    @(posedge clk);
    level[9] <= 10'h0E5;
    repeat (5) @(posedge clk);
    wr(CS, 8'h29);
    rd(CS, v);
    chk(v, 8'h29);
    poll();
    chk(mux_select, 4'h9);
    rd(HI, v);
    chk(v, 8'h39);
    wr(CS, 8'h00);
    repeat (3) @(posedge clk);
    chk(converter_power, 1'b0);
    repeat (60) @(posedge clk);
    rd(CS, v);
    chk(v, 8'h00);
    wr(CS, 8'h20);
    halt_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk({converter_power, result_settled}, 2'b00);
    halt_mode <= 1'b0;
    repeat (SC + 3) @(posedge clk);
    chk(result_settled, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(HI, 8'hFF);
    rd(CS, v);
    chk(v, 8'h00);
    rd(HI, v);
    chk(v, 8'h00);
    rd(LO, v);
    chk(v, 8'h00);
    report_and_stop();
  end
endmodule
